// >>> serial_shift_cfg.svh
// constants for the serial shift io control block
// assumes an 8-bit cpu side and a shift clock slower than mclk/4
`ifndef SERIAL_SHIFT_CFG_SVH
`define SERIAL_SHIFT_CFG_SVH
`define SH_DATA_W     8
`define SH_CNT_W      3
`define SH_CNT_ZERO   3'h0
`define SH_CNT_LAST   3'h7
`define SH_BYTE_ZERO  8'h00
`define SH_CNT_STEP   3'h1
`define SH_SDO_IDLE   1'b1
`endif

// >>> serial_shift_pkg.sv
// types for the serial shift io control block
// assumes serial_shift_cfg.svh is compiled alongside
package serial_shift_pkg;
  typedef enum logic [1:0] {
    st_idle  = 2'b01,
    st_shift = 2'b10
  } shift_state_e;
endpackage : serial_shift_pkg

// >>> edge_sync.sv
// two-flop synchroniser with edge detect for a pin input
// assumes the pin toggles slower than mclk/4
`timescale 1ns/100ps
module edge_sync (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // pin and decoded level and edges
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic       meta;
  logic       sync;
  logic       prev;
  logic [2:0] fill;
  logic       primed;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= pin;
      sync <= meta;
      prev <= sync;
    end
  end
  // reset levels need not match the idle pin, so edges wait for a full pipe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fill <= 3'h0;
    end else begin
      fill <= {fill[1:0], 1'b1};
    end
  end
  assign primed = fill[2];
  assign level  = sync;
  assign rise   = primed & sync & ~prev;
  assign fall   = primed & ~sync & prev;
endmodule : edge_sync

// >>> serial_shifter.sv
// serial shifter with edge select, counter clear/start, enable, interrupt gate
// assumes shift clock from a partner pin, control bits from a cpu register
// assumes strobes are one mclk wide and levels stay put during a byte
`timescale 1ns/100ps
`include "serial_shift_cfg.svh"
// Behaviour
// - edge select 0: drive on falling, sample rising; 1: reversed
// - writing clear 1 resets 3-bit counter and starts transfer; 0 does nothing
// - enable 0 halts shifter and counter; 1 lets them run
// - interrupt enable 0 blocks request to cpu; 1 passes it
module serial_shifter #(
  parameter int DATA_W = `SH_DATA_W
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // cpu control bits
  input  wire logic              edge_sel,
  input  wire logic              clr_start_wr,
  input  wire logic              shift_en,
  input  wire logic              irq_en,
  input  wire logic              lsb_first,
  input  wire logic              tx_mode,
  // cpu data
  input  wire logic              tx_load,
  input  wire logic [DATA_W-1:0] tx_data,
  output logic      [DATA_W-1:0] rx_data,
  output logic                   busy,
  output logic                   done,
  input  wire logic              done_clr,
  output logic                   irq,
  // serial pins
  input  wire logic              sck,
  input  wire logic              sdi,
  output logic                   sdo
);
  // the 3-bit counter closes a frame at eight bits; no other width is served
  if (DATA_W != `SH_DATA_W) begin : g_bad_width
    $error("serial_shifter supports only 8-bit data");
  end
  if ((1 << `SH_CNT_W) != DATA_W) begin : g_bad_count
    $error("serial_shifter counter does not span one data word");
  end

  // ==========================================================
  // pin sampling
  logic sck_rise;
  logic sck_fall;
  logic sdi_meta;
  logic sdi_sync;
  edge_sync u_sck (
    .mclk  (mclk),
    .rst   (rst),
    .pin   (sck),
    .level (),
    .rise  (sck_rise),
    .fall  (sck_fall)
  );
  // data is sampled at the same latency as the clock edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sdi_meta <= 1'b0;
      sdi_sync <= 1'b0;
    end else begin
      sdi_meta <= sdi;
      sdi_sync <= sdi_meta;
    end
  end

  // ==========================================================
  // edge selection
  logic drive_edge;
  logic sample_edge;
  // edges that arrive while idle or halted are dropped; no port reports it
  // edge polarity select
  assign drive_edge  = edge_sel ? sck_rise : sck_fall;
  assign sample_edge = edge_sel ? sck_fall : sck_rise;

  // ==========================================================
  // transfer state
  serial_shift_pkg::shift_state_e state;
  logic [`SH_CNT_W-1:0]           cnt;
  logic [`SH_CNT_W-1:0]           next_cnt;
  logic [DATA_W-1:0]              shreg;
  logic                           run;
  logic                           sample_now;
  logic                           drive_now;
  logic                           last_bit;
  assign run        = shift_en && (state == serial_shift_pkg::st_shift);
  assign sample_now = run && sample_edge;
  assign drive_now  = run && drive_edge;
  assign last_bit   = (cnt == `SH_CNT_LAST);
  // the counter wraps to zero on the eighth edge, ready for the next byte
  assign next_cnt   = cnt + `SH_CNT_STEP;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= serial_shift_pkg::st_idle;
    end else if (clr_start_wr) begin
      // clear starts transfer
      // a clear in flight restarts the bit count from zero; the shift register is not reloaded
      state <= serial_shift_pkg::st_shift;
    end else begin
      unique case (state)
        serial_shift_pkg::st_idle: begin
          state <= serial_shift_pkg::st_idle;
        end
        serial_shift_pkg::st_shift: begin
          if (sample_now && last_bit) begin
            state <= serial_shift_pkg::st_idle;
          end
        end
        default: begin
          state <= serial_shift_pkg::st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= `SH_CNT_ZERO;
    end else if (clr_start_wr) begin
      cnt <= `SH_CNT_ZERO;
    end else if (sample_now) begin
      cnt <= next_cnt;
    end
  end

  // ==========================================================
  // shift path selection
  logic [DATA_W-1:0] next_shreg;
  logic              load_now;
  logic              first_bit;
  logic              next_out;
  // loads are refused while busy, so a transfer never sees its byte change
  assign load_now = tx_load && !busy;

  // one shifted image serves both the shifter and the received byte
  always_comb begin
    if (lsb_first) begin
      next_shreg = {sdi_sync, shreg[DATA_W-1:1]};
    end else begin
      next_shreg = {shreg[DATA_W-2:0], sdi_sync};
    end
  end

  // a load in the start cycle must show the new byte, not the stale one
  always_comb begin
    if (lsb_first) begin
      first_bit = load_now ? tx_data[0] : shreg[0];
      next_out  = shreg[0];
    end else begin
      first_bit = load_now ? tx_data[DATA_W-1] : shreg[DATA_W-1];
      next_out  = shreg[DATA_W-1];
    end
  end

  // ==========================================================
  // shift register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      shreg <= `SH_BYTE_ZERO;
    end else if (load_now) begin
      shreg <= tx_data;
    end else if (sample_now) begin
      shreg <= next_shreg;
    end
  end

  // ==========================================================
  // output bit
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sdo <= `SH_SDO_IDLE;
    end else if (!tx_mode) begin
      // receive-only keeps the line at its idle level
      sdo <= `SH_SDO_IDLE;
    end else if (clr_start_wr || load_now) begin
      sdo <= first_bit;
    end else if (drive_now) begin
      sdo <= next_out;
    end
  end

  // ==========================================================
  // completion and interrupt
  logic finish;
  assign finish = sample_now && last_bit;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_data <= `SH_BYTE_ZERO;
    end else if (finish) begin
      rx_data <= next_shreg;
    end
  end

  // set wins over clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
    end else if (finish) begin
      done <= 1'b1;
    end else if (done_clr || clr_start_wr) begin
      done <= 1'b0;
    end
  end

  // ==========================================================
  // status outputs
  assign busy = (state == serial_shift_pkg::st_shift);
  assign irq  = done & irq_en;

endmodule : serial_shifter

// >>> serial_shifter_assertions.sv
// checker on serial shifter ports
// assumes mclk domain, rst active high
`timescale 1ns/100ps
module serial_shifter_assertions (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // watched ports
  input wire logic edge_sel,
  input wire logic clr_start_wr,
  input wire logic shift_en,
  input wire logic irq_en,
  input wire logic busy,
  input wire logic done,
  input wire logic irq,
  input wire logic sck,
  input wire logic sdo
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_drive_edge: assert property (
    busy && $changed(sdo) && !$past(clr_start_wr) |-> sck == edge_sel) else $error("bad sdo edge");
  chk_busy_start: assert property (clr_start_wr |=> busy) else $error("no start");
  chk_halt_hold: assert property (
    busy && !shift_en && !clr_start_wr |=> busy && !done) else $error("halt broken");
  chk_irq_gate: assert property (irq == (done && irq_en)) else $error("irq gate");
  chk_done_stop: assert property ($rose(done) |-> !busy && $past(busy)) else $error("bad end");
  cover property ($rose(done) && irq);
  cover property (busy && !shift_en);
  cover property ($rose(done) && edge_sel);
endmodule : serial_shifter_assertions
bind serial_shifter serial_shifter_assertions serial_shifter_assertions_i (.mclk(mclk),
  .rst(rst), .edge_sel(edge_sel), .clr_start_wr(clr_start_wr), .shift_en(shift_en),
  .irq_en(irq_en), .busy(busy), .done(done), .irq(irq), .sck(sck), .sdo(sdo));

// >>> serial_partner.sv
// far side shift device, makes sck in frames only
// assumes caller starts a frame via frame()
`timescale 1ns/100ps
module serial_partner (
  input  wire logic       edge_sel,
  input  wire logic       lsb_first,
  input  wire logic [7:0] out_byte,
  input  wire logic       sdo,
  output logic            sck,
  output logic            sdi,
  output logic [7:0]      in_byte
);
  initial begin
    sck = 1'b1;
    sdi = 1'b0;
  end
  task automatic frame;
    for (int i = 0; i < 8; i++) begin
      sdi = out_byte[lsb_first ? i : 7 - i];
      #20 sck = 1'b0;
      if (edge_sel) in_byte = {in_byte[6:0], sdo};
      #40 sck = 1'b1;
      if (!edge_sel) in_byte = {in_byte[6:0], sdo};
      #20;
    end
    // released line, no pull: show inverse
    sdi = ~sdi;
  endtask : frame
endmodule : serial_partner

// >>> serial_shifter_tb_top.sv
// bench for serial shifter with partner model
// assumes 4 ns mclk, inputs driven 1 ns after edge
`timescale 1ns/100ps
module serial_shifter_tb_top;
  logic mclk, rst, edge_sel, clr_start_wr, shift_en, irq_en, lsb_first, tx_mode;
  logic tx_load, done_clr, sck, sdi, busy, done, irq, sdo;
  logic [7:0] tx_data, rx_data, p_out, p_in;
  int err_count, compares, seed, k, n, r;
  localparam int P_LOAD  = 0;
  localparam int P_START = 1;
  localparam int P_CLR   = 2;
  serial_shifter serial_shifter_i (.mclk(mclk), .rst(rst), .edge_sel(edge_sel),
    .clr_start_wr(clr_start_wr), .shift_en(shift_en), .irq_en(irq_en), .lsb_first(lsb_first),
    .tx_mode(tx_mode), .tx_load(tx_load), .tx_data(tx_data), .rx_data(rx_data), .busy(busy),
    .done(done), .done_clr(done_clr), .irq(irq), .sck(sck), .sdi(sdi), .sdo(sdo));
  serial_partner serial_partner_i (.edge_sel(edge_sel), .lsb_first(lsb_first),
    .out_byte(p_out), .sdo(sdo), .sck(sck), .sdi(sdi), .in_byte(p_in));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  function automatic logic [7:0] order(input logic [7:0] b, input logic lsb);
    for (int i = 0; i < 8; i++) begin
      order[i] = lsb ? b[7 - i] : b[i];
    end
  endfunction : order
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic pulse(input int sel);
    if (sel == P_LOAD) tx_load = 1'b1;
    else if (sel == P_START) clr_start_wr = 1'b1;
    else done_clr = 1'b1;
    @(posedge mclk) #1;
    if (sel == P_LOAD) tx_load = 1'b0;
    else if (sel == P_START) clr_start_wr = 1'b0;
    else done_clr = 1'b0;
  endtask : pulse
  task automatic summarize;
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  initial begin
    #100us err_count++;
    summarize();
  end
  initial begin
    {edge_sel, clr_start_wr, shift_en, irq_en, lsb_first, tx_mode, tx_load, done_clr} = '0;
    {tx_data, p_out} = '0;
    rst = 1'b1;
    seed = 32'hbc53;
    repeat (20) @(posedge mclk);
    #1 rst = 1'b0;
    for (k = 0; k < 12; k++) begin
      r = $random(seed);
      // corner cases first: every mode bit seen at both levels
      if (k < 4) begin
        {edge_sel, lsb_first, irq_en, tx_mode} = {k[0], k[1], ~k[0], ~k[1]};
      end else begin
        {edge_sel, lsb_first, irq_en, tx_mode} = r[3:0];
      end
      tx_data = (k < 2) ? {8{k[0]}} : r[15:8];
      p_out = r[23:16];
      // halt case from the start of a run, held for a whole frame
      shift_en = (k != 3);
      pulse(P_LOAD);
      pulse(P_START);
      serial_partner_i.frame();
      @(posedge mclk) #1;
      if (!shift_en) begin
        chk("halted", 8'h02, {6'h0, busy, done});
        shift_en = 1'b1;
        pulse(P_START);
        serial_partner_i.frame();
      end
      n = 0;
      while (done !== 1'b1 && n < 100) begin
        @(posedge mclk) #1;
        n++;
      end
      chk("done", 8'h01, {7'h0, done});
      chk("rx_data", p_out, rx_data);
      chk("sdo byte", tx_mode ? order(tx_data, lsb_first) : 8'hff, p_in);
      chk("irq", {7'h0, irq_en}, {7'h0, irq});
      pulse(P_CLR);
      chk("done clear", 8'h00, {7'h0, done});
    end
    summarize();
  end
endmodule : serial_shifter_tb_top
